// file: hwm_pkg.sv
// Package of register indices, control fields and timing for the hardware multiplier.
package hwm_pkg;

    // Register indices; the AHB byte address of each register is four times its index.
    localparam logic [5:0] IDX_A_UNS = 6'h00;
    localparam logic [5:0] IDX_A_SGN = 6'h02;
    localparam logic [5:0] IDX_A_UNS_ACC = 6'h04;
    localparam logic [5:0] IDX_A_SGN_ACC = 6'h06;
    localparam logic [5:0] IDX_B_SHORT = 6'h08;
    localparam logic [5:0] IDX_RES_LOW = 6'h0A;
    localparam logic [5:0] IDX_RES_HIGH = 6'h0C;
    localparam logic [5:0] IDX_SUM_EXT = 6'h0E;
    localparam logic [5:0] IDX_WA_UNS_LO = 6'h10;
    localparam logic [5:0] IDX_WA_UNS_HI = 6'h12;
    localparam logic [5:0] IDX_WA_SGN_LO = 6'h14;
    localparam logic [5:0] IDX_WA_SGN_HI = 6'h16;
    localparam logic [5:0] IDX_WA_ACC_LO = 6'h18;
    localparam logic [5:0] IDX_WA_ACC_HI = 6'h1A;
    localparam logic [5:0] IDX_WA_SACC_LO = 6'h1C;
    localparam logic [5:0] IDX_WA_SACC_HI = 6'h1E;
    localparam logic [5:0] IDX_WB_LO = 6'h20;
    localparam logic [5:0] IDX_WB_HI = 6'h22;
    localparam logic [5:0] IDX_LRES_0 = 6'h24;
    localparam logic [5:0] IDX_LRES_1 = 6'h26;
    localparam logic [5:0] IDX_LRES_2 = 6'h28;
    localparam logic [5:0] IDX_LRES_3 = 6'h2A;
    localparam logic [5:0] IDX_CTL = 6'h2C;

    // Control register field positions.
    localparam int CTL_CARRY = 0;
    localparam int CTL_SIGNED = 4;
    localparam int CTL_ACCUM = 5;
    localparam int CTL_OPA_WIDE = 6;
    localparam int CTL_OPB_WIDE = 7;
    localparam int CTL_DLY_EN = 8;
    localparam int CTL_DLY_SHORT = 9;

    // Control reset value and the bits software may change.
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [15:0] CTL_WMASK = 16'h03FD;

    // Operation select field codes.
    typedef enum logic [1:0] {
        HWM_MUL_UNS = 2'b00,
        HWM_MUL_SGN = 2'b01,
        HWM_ACC_UNS = 2'b10,
        HWM_ACC_SGN = 2'b11
    } hwm_mode_t;

    // Cycles from start to the full 64-bit result; low words land in the first of them.
    localparam int RESULT_LATENCY = 3;

    // AHB-Lite encodings used by the slave.
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// file: hwm_top.sv
// Register-mapped multiply and multiply-accumulate unit with AHB-Lite slave and DMA trigger.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
// How it works
// - A ready pulse goes to the DMA controller once the product of an operation is in place.
// - The pulse comes when the low word is valid and the top word is valid by a fast read.
// - Every register takes word and byte access, low lane bits 7:0, high lane bits 15:8.
// - The address of the 16-bit first operand write selects one of the four operations.
// - A low byte write to a first-operand or short second-operand address loads 8 bits.
// - Second operand is 16 bits short or 32 bits split; a high-word byte gives 24 bits.
// - Each mode has a wide first operand; a byte to its high word gives 24 bits.
// - The short result sits in two words and the 64-bit result in four, lowest first.
// - The sum extension word is read only and ignores writes.
// - Control sits at its own index with its upper byte cleared at reset.
// - Short and wide aliases of first operand and result words act as one register.
// - Writing the second operand starts the operation in the chosen mode and widths.
// - Control bits 5:4 hold the operation code, unsigned, signed, accumulate, signed acc.
// - With delayed write on, writes wait for the 64-bit or, with bit 9, the 32-bit result.
// - Control bits 7 and 6 record the widths of the second and first operand.
module hwm_top #(
    parameter int RESULT_LATENCY = hwm_pkg::RESULT_LATENCY
) (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic [31:0] hrdata_out,
    output logic hresp_out,
    output logic dma_ready_out
);

    localparam logic [3:0] LAT = 4'(RESULT_LATENCY);

    logic accept;
    logic dp_valid;
    logic dp_write;
    logic [5:0] dp_idx;
    logic dp_lane;
    logic [2:0] dp_size;
    logic wr_done;
    logic rd_load;
    logic full16;
    logic wr_lo;
    logic wr_hi;
    logic byte8;
    logic [15:0] wdata;
    logic [15:0] ctl;
    logic [31:0] opnd_a;
    logic [31:0] opnd_b;
    logic [15:0] result_word [4];
    logic [15:0] sum_ext;
    logic [31:0] hold_high;
    logic [15:0] hold_ext;
    logic hold_carry;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic start;
    logic write_wait;
    logic [15:0] rd_val;
    logic a_low_write;
    logic a_high_write;
    logic [1:0] a_mode;
    logic sg;
    logic short_op;
    logic [32:0] a33;
    logic [32:0] b33;
    logic signed [65:0] prod;
    logic [63:0] prev;
    logic [32:0] sum33;
    logic [64:0] sum65;
    logic top_bit;
    logic [63:0] new64;
    logic [15:0] new_ext;

    // An address phase is taken only when the bus is ready and a transfer is requested.
    assign accept = hsel_in && (htrans_in == hwm_pkg::HTRANS_NONSEQ) && hready_in;
    assign wr_done = dp_valid && dp_write && hreadyout_out;
    assign rd_load = dp_valid && !dp_write && !hreadyout_out;

    // Byte lanes: a byte in lane 0 is the 8-bit alias, lane 1 is the upper byte.
    assign full16 = (dp_size != hwm_pkg::HSIZE_BYTE);
    assign wr_lo = full16 || !dp_lane;
    assign wr_hi = full16 || dp_lane;
    assign byte8 = !full16 && !dp_lane;
    assign wdata = hwdata_in[15:0];

    // Merge the written lanes into an old 16-bit value.
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nv,
                                          input logic lo, input logic hi);
        merge = {hi ? nv[15:8] : old[15:8], lo ? nv[7:0] : old[7:0]};
    endfunction

    // Classify first-operand writes and the mode their address selects.
    always_comb begin
        a_low_write = 1'b0;
        a_high_write = 1'b0;
        a_mode = ctl[5:4];
        case (dp_idx)
            hwm_pkg::IDX_A_UNS, hwm_pkg::IDX_A_SGN, hwm_pkg::IDX_A_UNS_ACC,
            hwm_pkg::IDX_A_SGN_ACC: begin
                a_low_write = 1'b1;
                a_mode = dp_idx[2:1];
            end
            hwm_pkg::IDX_WA_UNS_LO, hwm_pkg::IDX_WA_SGN_LO, hwm_pkg::IDX_WA_ACC_LO,
            hwm_pkg::IDX_WA_SACC_LO: begin
                a_low_write = 1'b1;
                a_mode = dp_idx[3:2];
            end
            hwm_pkg::IDX_WA_UNS_HI, hwm_pkg::IDX_WA_SGN_HI, hwm_pkg::IDX_WA_ACC_HI,
            hwm_pkg::IDX_WA_SACC_HI: begin
                a_high_write = 1'b1;
                a_mode = dp_idx[3:2];
            end
            default: begin
                a_low_write = 1'b0;
            end
        endcase
    end

    // A second-operand write that completes the operand starts the operation.
    assign start = wr_done && ((dp_idx == hwm_pkg::IDX_B_SHORT) ||
                               (dp_idx == hwm_pkg::IDX_WB_HI));

    // Progress counter: LAT right after start, low words land at LAT, high words at 1.
    always_comb begin
        if (start) begin
            next_cnt = LAT;
        end else if (cnt != 4'h0) begin
            next_cnt = cnt - 4'h1;
        end else begin
            next_cnt = 4'h0;
        end
    end

    // Writes held off while the awaited part of the result is still pending.
    assign write_wait = ctl[hwm_pkg::CTL_DLY_EN] &&
                        (ctl[hwm_pkg::CTL_DLY_SHORT] ? (next_cnt == LAT)
                                                      : (next_cnt != 4'h0));

    // Data phase tracking for the bus slave.
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_idx <= 6'h00;
            dp_lane <= 1'b0;
            dp_size <= 3'h0;
        end else if (accept) begin
            dp_valid <= 1'b1;
            dp_write <= hwrite_in;
            dp_idx <= haddr_in[7:2];
            dp_lane <= haddr_in[0];
            dp_size <= hsize_in;
        end else if (dp_valid && hreadyout_out) begin
            dp_valid <= 1'b0;
        end
    end

    // Ready: reads always take one wait state so the data comes from a flip-flop;
    // writes stall only while delayed write holds them.
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hreadyout_out <= 1'b1;
        end else if (accept) begin
            hreadyout_out <= hwrite_in ? !write_wait : 1'b0;
        end else if (dp_valid && !hreadyout_out) begin
            hreadyout_out <= dp_write ? !write_wait : 1'b1;
        end else begin
            hreadyout_out <= 1'b1;
        end
    end

    // Read data mux; unmapped indices read as zero.
    always_comb begin
        case (dp_idx)
            hwm_pkg::IDX_A_UNS, hwm_pkg::IDX_A_SGN, hwm_pkg::IDX_A_UNS_ACC,
            hwm_pkg::IDX_A_SGN_ACC, hwm_pkg::IDX_WA_UNS_LO, hwm_pkg::IDX_WA_SGN_LO,
            hwm_pkg::IDX_WA_ACC_LO, hwm_pkg::IDX_WA_SACC_LO: rd_val = opnd_a[15:0];
            hwm_pkg::IDX_WA_UNS_HI, hwm_pkg::IDX_WA_SGN_HI, hwm_pkg::IDX_WA_ACC_HI,
            hwm_pkg::IDX_WA_SACC_HI: rd_val = opnd_a[31:16];
            hwm_pkg::IDX_B_SHORT, hwm_pkg::IDX_WB_LO: rd_val = opnd_b[15:0];
            hwm_pkg::IDX_WB_HI: rd_val = opnd_b[31:16];
            hwm_pkg::IDX_RES_LOW, hwm_pkg::IDX_LRES_0: rd_val = result_word[0];
            hwm_pkg::IDX_RES_HIGH, hwm_pkg::IDX_LRES_1: rd_val = result_word[1];
            hwm_pkg::IDX_LRES_2: rd_val = result_word[2];
            hwm_pkg::IDX_LRES_3: rd_val = result_word[3];
            hwm_pkg::IDX_SUM_EXT: rd_val = sum_ext;
            hwm_pkg::IDX_CTL: rd_val = ctl & hwm_pkg::CTL_WMASK;
            default: rd_val = 16'h0000;
        endcase
    end

    // Read data and response; the response is always OKAY.
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hrdata_out <= 32'h0000_0000;
            hresp_out <= 1'b0;
        end else begin
            hresp_out <= 1'b0;
            if (rd_load) begin
                hrdata_out <= {16'h0000, rd_val};
            end
        end
    end

    // Operand registers carry no reset; their value is undefined until written.
    always_ff @(posedge clock_in) begin
        if (wr_done) begin
            if (a_low_write) begin
                if (byte8) begin
                    opnd_a[15:0] <= {{8{a_mode[0] & wdata[7]}}, wdata[7:0]};
                end else begin
                    opnd_a[15:0] <= merge(opnd_a[15:0], wdata, wr_lo, wr_hi);
                end
            end
            if (a_high_write) begin
                if (byte8) begin
                    opnd_a[31:16] <= {{8{a_mode[0] & wdata[7]}}, wdata[7:0]};
                end else begin
                    opnd_a[31:16] <= merge(opnd_a[31:16], wdata, wr_lo, wr_hi);
                end
            end
            if (dp_idx == hwm_pkg::IDX_B_SHORT) begin
                if (byte8) begin
                    opnd_b[15:0] <= {{8{ctl[hwm_pkg::CTL_SIGNED] & wdata[7]}}, wdata[7:0]};
                end else begin
                    opnd_b[15:0] <= merge(opnd_b[15:0], wdata, wr_lo, wr_hi);
                end
            end
            if (dp_idx == hwm_pkg::IDX_WB_LO) begin
                opnd_b[15:0] <= merge(opnd_b[15:0], wdata, wr_lo, wr_hi);
            end
            if (dp_idx == hwm_pkg::IDX_WB_HI) begin
                if (byte8) begin
                    opnd_b[31:16] <= {{8{ctl[hwm_pkg::CTL_SIGNED] & wdata[7]}}, wdata[7:0]};
                end else begin
                    opnd_b[31:16] <= merge(opnd_b[31:16], wdata, wr_lo, wr_hi);
                end
            end
        end
    end

    // Control register: software writes, mode and width tracking, and hardware carry.
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctl <= hwm_pkg::CTL_RESET;
        end else begin
            if (wr_done && (dp_idx == hwm_pkg::IDX_CTL)) begin
                ctl <= merge(ctl, wdata, wr_lo, wr_hi) & hwm_pkg::CTL_WMASK;
            end
            if (wr_done && a_low_write) begin
                ctl[5:4] <= a_mode;
                ctl[hwm_pkg::CTL_OPA_WIDE] <= 1'b0;
            end
            if (wr_done && a_high_write) begin
                ctl[5:4] <= a_mode;
                ctl[hwm_pkg::CTL_OPA_WIDE] <= 1'b1;
            end
            if (wr_done && (dp_idx == hwm_pkg::IDX_B_SHORT)) begin
                ctl[hwm_pkg::CTL_OPB_WIDE] <= 1'b0;
            end
            if (wr_done && (dp_idx == hwm_pkg::IDX_WB_HI)) begin
                ctl[hwm_pkg::CTL_OPB_WIDE] <= 1'b1;
            end
            // The hardware carry wins over a software write in the same cycle.
            if (cnt == 4'h1) begin
                ctl[hwm_pkg::CTL_CARRY] <= hold_carry;
            end
        end
    end

    // Arithmetic: operands widened by sign when signed, previous result added when accumulating.
    assign sg = ctl[hwm_pkg::CTL_SIGNED];
    assign short_op = !ctl[hwm_pkg::CTL_OPA_WIDE] && !ctl[hwm_pkg::CTL_OPB_WIDE];
    assign a33 = ctl[hwm_pkg::CTL_OPA_WIDE] ? {sg & opnd_a[31], opnd_a}
                                            : {{17{sg & opnd_a[15]}}, opnd_a[15:0]};
    assign b33 = ctl[hwm_pkg::CTL_OPB_WIDE] ? {sg & opnd_b[31], opnd_b}
                                            : {{17{sg & opnd_b[15]}}, opnd_b[15:0]};
    assign prod = $signed(a33) * $signed(b33);
    assign prev = ctl[hwm_pkg::CTL_ACCUM] ?
                  {result_word[3], result_word[2], result_word[1], result_word[0]}
                  : 64'h0000_0000_0000_0000;
    assign sum33 = {sg & prev[31], prev[31:0]} + {sg & prod[31], prod[31:0]};
    assign sum65 = {sg & prev[63], prev} + {sg & prod[63], prod[63:0]};
    assign top_bit = short_op ? sum33[32] : sum65[64];
    assign new64 = short_op ? {{32{sg & sum33[32]}}, sum33[31:0]} : sum65[63:0];
    assign new_ext = sg ? {16{top_bit}} : {15'h0000, top_bit};

    // Progress counter.
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt <= 4'h0;
        end else begin
            cnt <= next_cnt;
        end
    end

    // Result words: low half lands first, high half and extension LAT-1 cycles later.
    // Hardware updates take priority over software writes to the same word.
    always_ff @(posedge clock_in) begin
        if (wr_done) begin
            case (dp_idx)
                hwm_pkg::IDX_RES_LOW, hwm_pkg::IDX_LRES_0:
                    result_word[0] <= merge(result_word[0], wdata, wr_lo, wr_hi);
                hwm_pkg::IDX_RES_HIGH, hwm_pkg::IDX_LRES_1:
                    result_word[1] <= merge(result_word[1], wdata, wr_lo, wr_hi);
                hwm_pkg::IDX_LRES_2:
                    result_word[2] <= merge(result_word[2], wdata, wr_lo, wr_hi);
                hwm_pkg::IDX_LRES_3:
                    result_word[3] <= merge(result_word[3], wdata, wr_lo, wr_hi);
                default: begin
                end
            endcase
        end
        if (cnt == LAT) begin
            result_word[0] <= new64[15:0];
            result_word[1] <= new64[31:16];
            hold_high <= new64[63:32];
            hold_ext <= new_ext;
            hold_carry <= top_bit;
        end
        if (cnt == 4'h1) begin
            result_word[2] <= hold_high[15:0];
            result_word[3] <= hold_high[31:16];
            sum_ext <= hold_ext;
        end
    end

    // DMA trigger: one pulse per operation, in the same edge the low words become valid;
    // the top words follow well before a back-to-back reader can reach them.
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dma_ready_out <= 1'b0;
        end else begin
            dma_ready_out <= (cnt == LAT);
        end
    end

endmodule // hwm_top

// file: hwm_checker.sv
// Checker of bus timing and ready pulse for the multiplier.
`timescale 1ns/1ps
module hwm_checker #(
    parameter int RESULT_LATENCY = 3
) (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic hreadyout_out,
    input wire logic [31:0] hrdata_out,
    input wire logic hresp_out,
    input wire logic dma_ready_out
);
    // A delayed write may wait out a whole operation, so allow twice its latency.
    localparam int WMAX = 6;
    logic acc;
    logic rd_acc;
    logic start;
    logic b_phase;
    logic b_done;
    // Accepted transfers, and writes of the second operand that start an operation.
    assign acc = hsel_in && htrans_in == hwm_pkg::HTRANS_NONSEQ && hready_in;
    assign rd_acc = acc && !hwrite_in;
    assign start = acc && hwrite_in && (haddr_in[7:2] == hwm_pkg::IDX_B_SHORT ||
        haddr_in[7:2] == hwm_pkg::IDX_WB_HI);
    // A delayed write may stall the starting write, so the operation begins when its data
    // phase ends, not when its address is taken.
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            b_phase <= 1'b0;
        end else if (start) begin
            b_phase <= 1'b1;
        end else if (hreadyout_out) begin
            b_phase <= 1'b0;
        end
    end
    assign b_done = b_phase && hreadyout_out;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    okay_resp_a: assert property (hresp_out == 1'b0) else $error("Response not OKAY.");
    upper_zero_a: assert property (hrdata_out[31:16] == 16'h0000) else $error("Upper read bits set.");
    read_wait_a: assert property (rd_acc |=> !hreadyout_out ##1 hreadyout_out)
        else $error("Read wait state wrong.");
    rdata_hold_a: assert property (!$stable(hrdata_out) |-> $past(rd_acc, 2))
        else $error("Read data moved without a read.");
    write_done_a: assert property (acc && hwrite_in |-> ##[1:WMAX] hreadyout_out)
        else $error("Write never completed.");
    ready_drop_a: assert property ($fell(hreadyout_out) |-> $past(acc))
        else $error("Ready dropped without a transfer.");
    dma_timing_a: assert property (b_done |-> ##2 dma_ready_out)
        else $error("Ready pulse late or missing.");
    dma_cause_a: assert property (dma_ready_out |-> $past(b_done, 2))
        else $error("Ready pulse without a start.");
    dma_pulse_a: assert property (dma_ready_out |=> !dma_ready_out)
        else $error("Ready pulse longer than one cycle.");
    // Main scenarios reached.
    read_seen_c: cover property (rd_acc);
    start_seen_c: cover property (start);
    dma_seen_c: cover property (dma_ready_out);
endmodule // hwm_checker
bind hwm_top hwm_checker #(.RESULT_LATENCY(RESULT_LATENCY)) u_chk (.clock_in(clock_in),
    .arst_n_in(arst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
    .hreadyout_out(hreadyout_out), .hrdata_out(hrdata_out), .hresp_out(hresp_out),
    .dma_ready_out(dma_ready_out));

// file: hwm_dma_model.sv
// Bus master model standing for the DMA controller and the CPU.
`timescale 1ns/1ps
module hwm_dma_model (
    input wire logic clock_in,
    input wire logic hreadyout_in,
    input wire logic [31:0] hrdata_in,
    input wire logic dma_ready_in,
    output logic hsel_out,
    output logic [31:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic hwrite_out,
    output logic [2:0] hsize_out,
    output logic [31:0] hwdata_out
);
    logic [15:0] words [4];
    // Idle bus at time zero.
    initial begin
        hsel_out = 1'b0;
        haddr_out = 32'h0000_0000;
        htrans_out = 2'b00;
        hwrite_out = 1'b0;
        hsize_out = 3'h2;
        hwdata_out = 32'h0000_0000;
    end
    // One single transfer; released address and write data show the inverse so stale values never look valid.
    task automatic xfer(input logic wr, input logic [2:0] sz, input logic [31:0] addr,
            input logic [15:0] wdata, output logic [15:0] rdata);
        hsel_out <= 1'b1;
        haddr_out <= addr;
        htrans_out <= hwm_pkg::HTRANS_NONSEQ;
        hwrite_out <= wr;
        hsize_out <= sz;
        @(posedge clock_in);
        while (hreadyout_in !== 1'b1) @(posedge clock_in);
        hsel_out <= 1'b0;
        htrans_out <= 2'b00;
        haddr_out <= ~addr;
        hwdata_out <= {16'h0000, wdata};
        @(posedge clock_in);
        while (hreadyout_in !== 1'b1) @(posedge clock_in);
        rdata = hrdata_in[15:0];
        hwdata_out <= ~{16'h0000, wdata};
    endtask
    // Wait a bounded time for the pulse, then read n words lowest first, back to back.
    task automatic serve(input int n, output logic got);
        logic [15:0] d;
        got = 1'b0;
        for (int i = 0; i < 20 && !got; i++) begin
            @(posedge clock_in);
            got = dma_ready_in === 1'b1;
        end
        for (int i = 0; i < n && got; i++) begin
            xfer(1'b0, 3'h2, 32'({hwm_pkg::IDX_LRES_0 + 6'(2 * i), 2'b00}), 16'h0000, d);
            words[i] = d;
        end
    endtask
endmodule // hwm_dma_model

// file: hwm_top_bench.sv
// Self-checking bench of the register-mapped multiplier.
`timescale 1ns/1ps
module hwm_top_bench;
    localparam int LAT = 3;
    logic clock_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, dma_ready;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int error_cnt = 0;
    int num_checks = 0;
    // Free-running 200 MHz clock.
    always #2.5 clock_in = ~clock_in;
    hwm_top #(.RESULT_LATENCY(LAT)) DUT (.clock_in(clock_in), .arst_n_in(arst_n_in),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout),
        .hreadyout_out(hreadyout), .hrdata_out(hrdata), .hresp_out(hresp),
        .dma_ready_out(dma_ready));
    hwm_dma_model bus (.clock_in(clock_in), .hreadyout_in(hreadyout), .hrdata_in(hrdata),
        .dma_ready_in(dma_ready), .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans),
        .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));
    // Shared comparison; unknown bits never pass.
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] idx, input logic [15:0] d);
        logic [15:0] r;
        bus.xfer(1'b1, 3'h2, {24'h00_0000, idx, 2'b00}, d, r);
    endtask
    task automatic rd(input logic [5:0] idx, output logic [15:0] r);
        bus.xfer(1'b0, 3'h2, {24'h00_0000, idx, 2'b00}, 16'h0000, r);
    endtask
    task automatic rd_chk(input logic [5:0] idx, input logic [15:0] exp);
        logic [15:0] r;
        rd(idx, r);
        check(64'(r), 64'(exp));
    endtask
    // Control resets clear; an unmapped place reads zero.
    task automatic t_reset();
        rd_chk(hwm_pkg::IDX_CTL, 16'h0000);
        rd_chk(6'h30, 16'h0000);
    endtask
    // Every mode in turn; accumulate modes build on the previous result.
    task automatic t_modes();
        logic [5:0] ai [4] = '{hwm_pkg::IDX_A_UNS, hwm_pkg::IDX_A_UNS_ACC, hwm_pkg::IDX_A_SGN,
            hwm_pkg::IDX_A_SGN_ACC};
        logic [1:0] code [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
        logic [15:0] a [4] = '{16'hFFFF, 16'h0002, 16'hFFFE, 16'h0002};
        logic [15:0] b [4] = '{16'hFFFF, 16'h0003, 16'h0003, 16'h0003};
        logic [31:0] res, p;
        logic [15:0] r;
        logic got;
        res = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            wr(ai[i], a[i]);
            wr(hwm_pkg::IDX_B_SHORT, b[i]);
            bus.serve(4, got);
            p = code[i][0] ? 32'(signed'(a[i])) * 32'(signed'(b[i])) : 32'(a[i]) * 32'(b[i]);
            res = (code[i][1] ? res : 32'h0000_0000) + p;
            check(64'(got), 64'h1);
            check(64'({bus.words[1], bus.words[0]}), 64'(res));
            check(64'({bus.words[3], bus.words[2]}), 64'({32{code[i][0] & res[31]}}));
            rd_chk(hwm_pkg::IDX_RES_LOW, res[15:0]);
            rd_chk(hwm_pkg::IDX_RES_HIGH, res[31:16]);
            rd(hwm_pkg::IDX_CTL, r);
            check(64'(r & 16'h00F0), 64'({code[i], 4'h0}));
        end
        rd(hwm_pkg::IDX_SUM_EXT, r);
        wr(hwm_pkg::IDX_SUM_EXT, ~r);
        rd_chk(hwm_pkg::IDX_SUM_EXT, r);
    endtask
    // A 32 by 32 product through the split operands.
    task automatic t_wide();
        logic [15:0] r;
        logic got;
        wr(hwm_pkg::IDX_WA_UNS_LO, 16'h5678);
        wr(hwm_pkg::IDX_WA_UNS_HI, 16'h1234);
        wr(hwm_pkg::IDX_WB_LO, 16'hDEF0);
        wr(hwm_pkg::IDX_WB_HI, 16'h9ABC);
        bus.serve(4, got);
        check({bus.words[3], bus.words[2], bus.words[1], bus.words[0]},
            64'h1234_5678 * 64'h9ABC_DEF0);
        rd(hwm_pkg::IDX_CTL, r);
        check(64'(r & 16'h00C0), 64'h00C0);
        rd_chk(hwm_pkg::IDX_A_UNS, 16'h5678);
    endtask
    // Byte operands, a short DMA read, then a write held back by delayed-write mode.
    task automatic t_bytes();
        logic [15:0] r;
        logic got;
        time t0;
        bus.xfer(1'b1, hwm_pkg::HSIZE_BYTE, {24'h00_0000, hwm_pkg::IDX_A_SGN, 2'b00}, 16'h0082, r);
        bus.xfer(1'b1, hwm_pkg::HSIZE_BYTE, {24'h00_0000, hwm_pkg::IDX_B_SHORT, 2'b00}, 16'h0004, r);
        bus.serve(2, got);
        check(64'({bus.words[1], bus.words[0]}), 64'h0000_0000_FFFF_FE08);
        bus.xfer(1'b1, hwm_pkg::HSIZE_BYTE, {24'h00_0000, hwm_pkg::IDX_CTL, 2'b01}, 16'h0100, r);
        rd(hwm_pkg::IDX_CTL, r);
        check(64'(r & 16'h0300), 64'h0100);
        wr(hwm_pkg::IDX_A_UNS, 16'h0003);
        wr(hwm_pkg::IDX_B_SHORT, 16'h0005);
        t0 = $time;
        wr(hwm_pkg::IDX_CTL, 16'h0000);
        check(64'(($time - t0) > 10), 64'h1);
        rd_chk(hwm_pkg::IDX_LRES_3, 16'h0000);
        rd_chk(hwm_pkg::IDX_LRES_0, 16'h000F);
        rd_chk(hwm_pkg::IDX_CTL, 16'h0000);
    endtask
    // Verdict and end of run.
    task automatic finish_test();
        $display("Checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Main sequence after three reset cycles.
    initial begin
        repeat (3) @(posedge clock_in);
        arst_n_in <= 1'b1;
        @(posedge clock_in);
        t_reset();
        t_modes();
        t_wide();
        t_bytes();
        finish_test();
    end
    // Watchdog far beyond the few hundred cycles the tests need.
    initial begin
        #20000;
        error_cnt++;
        finish_test();
    end
endmodule // hwm_top_bench
